// ==== hdl/pdda_port.sv ====
// Behaviour
// - A read of the data location returns the synchronised pin level for input pins.
// - A read of the data location returns the latch bit for output pins.
// - A write to the data location loads all eight latch bits, input pins included.
// - An output pin drives its latch bit level.
// - A direction bit of one makes the pin an output, zero releases the driver.
// - The direction bits are write-only and their stored value is never read back.
// - A read of the direction location always returns all ones.
`include "pdda_regs.svh"
module pdda_port
   import pdda_pkg::*;
#(
   parameter int PINS = 8
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // CPU access
   input  wire pdda_req_t  req,
   output pdda_byte_t      rdata,
   // Port pins
   input  wire logic [7:0] pinIn,
   output logic      [7:0] pinOut,
   output logic      [7:0] pinOe_n
);
   // Byte-wide registers serve exactly eight pins
   if (PINS != 8) begin : g_pinsCheck
      $error("pdda_port serves exactly eight pins");
   end

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rstMeta_r;
   logic rstSync_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------
   pdda_byte_t pinSync;
   pdda_sync #(.WIDTH(8)) uSync (
      .clk     (clk),
      .rst_n   (rstSync_r),
      .asyncIn (pinIn),
      .syncOut (pinSync)
   );

   // ------------------------------------------------------------
   // Latch and direction registers
   // ------------------------------------------------------------
   pdda_byte_t portOutputLatch_r;
   pdda_byte_t portOutputLatch_nxt;
   pdda_byte_t portDirectionControl_r;
   pdda_byte_t portDirectionControl_nxt;
   pdda_byte_t rdata_r;
   pdda_byte_t rdata_nxt;

   always_comb begin
      portOutputLatch_nxt      = portOutputLatch_r;
      portDirectionControl_nxt = portDirectionControl_r;
      if (req.wr && req.sel == `PDDA_SEL_LATCH) begin
         portOutputLatch_nxt = req.wdata;
      end
      if (req.wr && req.sel == `PDDA_SEL_DIR) begin
         portDirectionControl_nxt = req.wdata;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = rdata_r;
      if (req.rd) begin
         case (req.sel)
            `PDDA_SEL_LATCH: begin
               // Per pin: latch for outputs, pin level for inputs
               rdata_nxt = (portDirectionControl_r & portOutputLatch_r)
                         | (~portDirectionControl_r & pinSync);
            end
            `PDDA_SEL_DIR: begin
               rdata_nxt = `PDDA_DIR_READ_VALUE;
            end
            default: begin
               rdata_nxt = `PDDA_UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         portOutputLatch_r      <= `PDDA_LATCH_RST;
         portDirectionControl_r <= `PDDA_DIR_RST;
         rdata_r                <= 8'h00;
      end else begin
         portOutputLatch_r      <= portOutputLatch_nxt;
         portDirectionControl_r <= portDirectionControl_nxt;
         rdata_r                <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   assign pinOut  = portOutputLatch_r;
   assign pinOe_n = ~portDirectionControl_r;
   assign rdata   = rdata_r;
endmodule // pdda_port

// ==== hdl/pdda_sync.sv ====
`include "pdda_regs.svh"
module pdda_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end
   assign syncOut = stage2_r;
endmodule // pdda_sync

// ==== inc/pdda_pkg.sv ====
package pdda_pkg;
   typedef logic [7:0] pdda_byte_t;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [1:0] sel;
      pdda_byte_t wdata;
   } pdda_req_t;
endpackage

// ==== inc/pdda_regs.svh ====
`ifndef PDDA_REGS_SVH
`define PDDA_REGS_SVH
// ------------------------------------------------------------
// Port register map and reset values
// ------------------------------------------------------------
`define PDDA_ADDR_W         2
`define PDDA_SEL_LATCH      2'h0
`define PDDA_SEL_DIR        2'h1
`define PDDA_LATCH_RST      8'h00
`define PDDA_DIR_RST        8'h00
`define PDDA_DIR_READ_VALUE 8'hff
`define PDDA_UNMAPPED_READ  8'hff
`endif

// ==== sim/pdda_pin_model.sv ====
module pdda_pin_model (
   // Port side
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOe_n,
   // Outside world
   input  wire logic [7:0] extLevel,
   output logic      [7:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Driven pins follow the latch, released pins the outside level
   assign pinIn = (pinOut & ~pinOe_n) | (extLevel & pinOe_n);
endmodule // pdda_pin_model

// ==== sim/pdda_props.sv ====
module pdda_props
   import pdda_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Port
   input wire pdda_req_t  req,
   input wire pdda_byte_t rdata,
   input wire logic [7:0] pinIn,
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rdLat; req.rd && req.sel == 2'h0; endsequence
   sequence pinQuiet; $stable(pinIn) [*4]; endsequence
   latch_load_a: assert property (req.wr && req.sel == 2'h0 |=> pinOut == $past(req.wdata))
      else $error("latch not loaded");
   dir_load_a: assert property (req.wr && req.sel == 2'h1 |=> pinOe_n == ~$past(req.wdata))
      else $error("direction not loaded");
   dir_read_a: assert property (req.rd && req.sel == 2'h1 |=> rdata == 8'hff)
      else $error("direction read not ff");
   out_read_a: assert property (rdLat |=> (rdata & ~$past(pinOe_n)) == ($past(pinOut) & ~$past(pinOe_n)))
      else $error("output bits not from latch");
   in_read_a: assert property (pinQuiet ##0 rdLat |=>
      (rdata & $past(pinOe_n)) == ($past(pinIn) & $past(pinOe_n)))
      else $error("input bits not from pins");
   out_hold_a: assert property (!(req.wr && req.sel == 2'h0) |=> $stable(pinOut))
      else $error("pins moved without write");
   dir_hold_a: assert property (!(req.wr && req.sel == 2'h1) |=> $stable(pinOe_n))
      else $error("direction moved without write");
   rd_hold_a: assert property (!req.rd |=> $stable(rdata))
      else $error("read data moved");
endmodule // pdda_props

// ==== sim/pdda_tb_top.sv ====
bind pdda_port pdda_props i_pdda_props (.clk, .rst_n, .req, .rdata, .pinIn, .pinOut, .pinOe_n);
module pdda_tb_top import pdda_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 0, rst_n = 0;
   pdda_req_t  req = '0;
   pdda_byte_t rdata, pinOut, pinOe_n, pinIn, ext = 8'h00, got;
   int         n_fail = 0, cmp_count = 0, cyc = 0;
   always #50 clk = ~clk;
   always @(posedge clk) if (++cyc == 2000) begin n_fail++; results(); end
   pdda_port i_pdda_port (.clk, .rst_n, .req, .rdata, .pinIn, .pinOut, .pinOe_n);
   pdda_pin_model i_pdda_pin_model (.pinOut, .pinOe_n, .extLevel(ext), .pinIn);
   task chk(input pdda_byte_t g, input pdda_byte_t e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task acc(input logic w, input logic [1:0] s, input pdda_byte_t d);
      @(negedge clk) req = '{rd: !w, wr: w, sel: s, wdata: d};
      @(negedge clk) req = '0;
      got = rdata;
   endtask
   task t_bitset;
      acc(1, 2'h1, 8'h3f);
      acc(1, 2'h0, 8'h80);
      ext = 8'h40;
      repeat (3) @(negedge clk);
      acc(0, 2'h0, 8'h00);
      chk(got, 8'h40);
      acc(1, 2'h0, got | 8'h01);
      chk(pinOut, 8'h41);
      chk(pinOe_n, 8'hc0);
      acc(0, 2'h0, 8'h00);
      chk(got, 8'h41);
   endtask
   task t_bitclr;
      acc(0, 2'h1, 8'h00);
      chk(got, 8'hff);
      acc(1, 2'h1, got & 8'hfe);
      chk(pinOe_n, 8'h01);
      acc(1, 2'h3, 8'h00);
      chk(pinOut, 8'h41);
      acc(0, 2'h2, 8'h00);
      chk(got, 8'hff);
   endtask
   task results;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      repeat (4) @(negedge clk);
      chk(pinOe_n, 8'hff);
      chk(pinOut, 8'h00);
      t_bitset();
      t_bitclr();
      results();
   end
endmodule // pdda_tb_top
